// ==== src/cpllr_pkg.sv ====
/*
 * chipset pll control byte map: offsets, reset values, decode tables.
 * assumes one 40 MHz reference clock; smbus pins sampled on that clock.
 */
package cpllr_pkg;

   // ------------------------------------------------------------
   // byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_REF_DIV   = 8'h10;
   localparam logic [7:0] REG_FB_HIGH   = 8'h11;
   localparam logic [7:0] REG_SPR_LOW   = 8'h12;
   localparam logic [7:0] REG_SPR_HIGH  = 8'h13;
   localparam logic [7:0] REG_POST_DIV  = 8'h14;
   localparam logic [7:0] REG_PART_ID   = 8'h15;
   localparam logic [7:0] REG_PROG_EN   = 8'h16;
   localparam logic [7:0] REG_REQ_GATE  = 8'h17;
   localparam int         NUM_REGS      = 8;

   // ------------------------------------------------------------
   // field positions and masks
   // ------------------------------------------------------------
   localparam int         MAIN_EN_BIT   = 7;
   localparam int         CS_EN_BIT     = 6;
   localparam int         FB_LSB_BIT    = 7;
   localparam logic [7:0] POST_WR_MASK  = 8'h8f;

   // ------------------------------------------------------------
   // reset values (power-up divider setting)
   // ------------------------------------------------------------
   localparam logic [7:0] RST_REF_DIV   = 8'h0e;
   localparam logic [7:0] RST_FB_HIGH   = 8'h1f;
   localparam logic [7:0] RST_POST_DIV  = 8'h80;
   localparam logic [7:0] RST_PROG_EN   = 8'h00;
   localparam logic [7:0] RST_REQ_GATE  = 8'h3f;
   localparam logic [7:0] RST_VALS [NUM_REGS] = '{RST_REF_DIV, RST_FB_HIGH, 8'h00, 8'h00,
                                                  RST_POST_DIV, 8'h00, RST_PROG_EN,
                                                  RST_REQ_GATE};

   // identification and smbus address: arbitrary values
   localparam logic [7:0] PART_ID_CODE  = 8'h5a;
   localparam logic [6:0] SMB_ADDR      = 7'h69;

   // ------------------------------------------------------------
   // pll arithmetic and post divider ratios
   // ------------------------------------------------------------
   localparam logic [24:0] VCO_REF_KHZ  = 25'd14318;
   localparam logic [6:0] POST_RATIO [16] = '{7'd2, 7'd3, 7'd5, 7'd15, 7'd4, 7'd6, 7'd10,
                                             7'd18, 7'd8, 7'd12, 7'd20, 7'd36, 7'd16,
                                             7'd24, 7'd40, 7'd72};

   // ------------------------------------------------------------
   // serial engine
   // ------------------------------------------------------------
   localparam logic [3:0] BYTE_BITS     = 4'd8;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ACKA = 9'h004,
      ST_CMD  = 9'h008,
      ST_ACKC = 9'h010,
      ST_WDAT = 9'h020,
      ST_ACKW = 9'h040,
      ST_RDAT = 9'h080,
      ST_RACK = 9'h100
   } cpllr_state_type;

endpackage

// ==== src/cpllr_reg_if.sv ====
/*
 * byte access path between the smbus engine and the control bytes.
 * assumes rdata is a combinational view of the addressed byte.
 */
`timescale 1ns/1ps
`default_nettype none
interface cpllr_reg_if;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport target (output wr, output addr, output wdata, input rdata);
   modport regs   (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== src/cpllr_smbus_target.sv ====
/*
 * smbus byte engine: address, command byte, auto-incrementing data.
 * assumes scl and sda are synchronous to ref_clk and far slower.
 */
`timescale 1ns/1ps
`default_nettype none
module cpllr_smbus_target (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // smbus pins
   input  wire logic       smb_clk_i,
   input  wire logic       smb_dat_i,
   output logic            smb_dat_oe_o,
   // byte access
   cpllr_reg_if.target     bus
);
   import cpllr_pkg::*;

   cpllr_state_type st_q, st_d;
   logic       scl_q, sda_q, oe_q, oe_d, rw_q, rw_d, wr_q, wr_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   logic       scl_rise, scl_fall, start_ev, stop_ev;

   // ------------------------------------------------------------
   // bus events and byte sequencing
   // ------------------------------------------------------------
   always_comb begin
      scl_rise = smb_clk_i & ~scl_q;
      scl_fall = ~smb_clk_i & scl_q;
      start_ev = scl_q & smb_clk_i & sda_q & ~smb_dat_i;
      stop_ev  = scl_q & smb_clk_i & ~sda_q & smb_dat_i;
      st_d  = st_q;
      oe_d  = oe_q;
      rw_d  = rw_q;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      ptr_d = ptr_q;
      wr_d  = 1'b0;
      if (start_ev) begin
         st_d  = ST_ADDR;
         cnt_d = 4'h0;
         oe_d  = 1'b0;
      end else if (stop_ev) begin
         st_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_CMD, ST_WDAT: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], smb_dat_i};
                  cnt_d = 4'(cnt_q + 4'h1);
               end else if (scl_fall && cnt_q == BYTE_BITS) begin
                  cnt_d = 4'h0;
                  if (st_q == ST_ADDR) begin
                     if (sh_q[7:1] == SMB_ADDR) begin
                        oe_d = 1'b1;
                        rw_d = sh_q[0];
                        st_d = ST_ACKA;
                     end else begin
                        st_d = ST_IDLE;
                     end
                  end else if (st_q == ST_CMD) begin
                     ptr_d = sh_q;
                     oe_d  = 1'b1;
                     st_d  = ST_ACKC;
                  end else begin
                     wr_d = 1'b1;
                     oe_d = 1'b1;
                     st_d = ST_ACKW;
                  end
               end
            end
            ST_ACKA, ST_ACKC, ST_ACKW: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  if (st_q == ST_ACKW) begin
                     ptr_d = 8'(ptr_q + 8'h01);
                  end
                  if (st_q == ST_ACKA && rw_q) begin
                     sh_d  = bus.rdata;
                     oe_d  = ~bus.rdata[7];
                     cnt_d = 4'h1;
                     ptr_d = 8'(ptr_q + 8'h01);
                     st_d  = ST_RDAT;
                  end else if (st_q == ST_ACKA) begin
                     st_d = ST_CMD;
                  end else begin
                     st_d = ST_WDAT;
                  end
               end
            end
            ST_RDAT: begin
               if (scl_fall && cnt_q == BYTE_BITS) begin
                  oe_d = 1'b0;
                  st_d = ST_RACK;
               end else if (scl_fall) begin
                  sh_d  = {sh_q[6:0], 1'b0};
                  oe_d  = ~sh_q[6];
                  cnt_d = 4'(cnt_q + 4'h1);
               end
            end
            ST_RACK: begin
               if (scl_rise && smb_dat_i) begin
                  st_d = ST_IDLE;
               end else if (scl_fall) begin
                  sh_d  = bus.rdata;
                  oe_d  = ~bus.rdata[7];
                  cnt_d = 4'h1;
                  ptr_d = 8'(ptr_q + 8'h01);
                  st_d  = ST_RDAT;
               end
            end
            default: begin
               st_d = st_q;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q  <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         oe_q  <= 1'b0;
         rw_q  <= 1'b0;
         wr_q  <= 1'b0;
         cnt_q <= 4'h0;
         sh_q  <= 8'h00;
         ptr_q <= 8'h00;
      end else begin
         st_q  <= st_d;
         scl_q <= smb_clk_i;
         sda_q <= smb_dat_i;
         oe_q  <= oe_d;
         rw_q  <= rw_d;
         wr_q  <= wr_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         ptr_q <= ptr_d;
      end
   end

   assign smb_dat_oe_o = oe_q;
   assign bus.wr       = wr_q;
   assign bus.addr     = ptr_q;
   assign bus.wdata    = sh_q;

endmodule
`default_nettype wire

// ==== src/cpllr_chipset_pll_regs.sv ====
/*
 * chipset pll control bytes behind an smbus target, with divider
 * hold-off, post divider decode and clock-request gating.
 * assumes one 40 MHz clock; smbus pins synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - byte 0x10 bits 5:0 hold the six-bit chipset reference divider, read-write.
// - feedback divider is byte 0x11, byte 0x10 bits 7:6, byte 0x14 bit 7.
// - vco frequency equals 14.318 MHz times feedback over reference divider.
// - spread amount takes low byte from 0x12 and high byte from 0x13.
// - byte 0x14 bits 3:0 select post divider ratio from fixed table.
// - byte 0x15 returns a fixed identification code; writes ignored.
// - byte 0x16 bit 7 main, bit 6 chipset programming enable, reset 0.
// - byte 0x17 bits 5:0 let request inputs gate outputs; reset to ones.
module cpllr_chipset_pll_regs (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   // smbus pins
   input  wire logic        smb_clk_i,
   input  wire logic        smb_dat_i,
   output logic             smb_dat_o,
   output logic             smb_dat_oe_o,
   // clock request inputs
   input  wire logic [4:0]  clock_request_n_i,
   // chipset pll settings
   output logic [5:0]       ref_divider_o,
   output logic [10:0]      feedback_divider_o,
   output logic [24:0]      vco_khz_o,
   output logic [15:0]      spread_amount_o,
   output logic [6:0]       chipset_post_divider_o,
   // enables and output gating
   output logic             main_pll_program_enable_o,
   output logic             chipset_pll_program_enable_o,
   output logic [5:0]       clock_run_o
);
   import cpllr_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_q, rst_n_q;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // smbus engine
   // ------------------------------------------------------------
   cpllr_reg_if bus ();

   cpllr_smbus_target u_target (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_q),
      .smb_clk_i    (smb_clk_i),
      .smb_dat_i    (smb_dat_i),
      .smb_dat_oe_o (smb_dat_oe_o),
      .bus          (bus)
   );

   // ------------------------------------------------------------
   // control bytes
   // ------------------------------------------------------------
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic [2:0] idx;
   logic       in_map;

   always_comb begin
      idx    = bus.addr[2:0];
      in_map = (bus.addr >= REG_REF_DIV) && (bus.addr <= REG_REQ_GATE);
      regs_d = regs_q;
      if (!bus.wr) begin
         regs_d = regs_q;
      end else if (bus.addr == REG_PART_ID) begin
         regs_d = regs_q;
      end else if (bus.addr == REG_POST_DIV) begin
         regs_d[idx] = bus.wdata & POST_WR_MASK;
      end else if (in_map) begin
         regs_d[idx] = bus.wdata;
      end
   end

   always_comb begin
      if (bus.addr == REG_PART_ID) begin
         bus.rdata = PART_ID_CODE;
      end else if (in_map) begin
         bus.rdata = regs_q[idx];
      end else begin
         bus.rdata = 8'h00;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         regs_q <= RST_VALS;
      end else begin
         regs_q <= regs_d;
      end
   end

   // ------------------------------------------------------------
   // effective pll settings
   // ------------------------------------------------------------
   logic        cs_en;
   logic [5:0]  ref_eff;
   logic [10:0] fb_eff;
   logic [24:0] vco_d;
   logic [5:0]  run_d;
   logic [5:0]  gate;
   logic [5:0]  req_n;

   always_comb begin
      cs_en = regs_q[6][CS_EN_BIT];
      if (cs_en) begin
         ref_eff = regs_q[0][5:0];
         fb_eff  = {regs_q[1], regs_q[0][7:6], regs_q[4][FB_LSB_BIT]};
      end else begin
         ref_eff = RST_REF_DIV[5:0];
         fb_eff  = {RST_FB_HIGH, RST_REF_DIV[7:6], RST_POST_DIV[FB_LSB_BIT]};
      end
      if (ref_eff == 6'h00) begin
         vco_d = 25'h0;
      end else begin
         vco_d = 25'((VCO_REF_KHZ * 25'(fb_eff)) / 25'(ref_eff));
      end
      gate  = regs_q[7][5:0];
      req_n = {clock_request_n_i[4], clock_request_n_i};
      run_d = ~gate | ~req_n;
   end

   logic smb_dat_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ref_divider_o                <= RST_REF_DIV[5:0];
         feedback_divider_o           <= 11'h0;
         vco_khz_o                    <= 25'h0;
         spread_amount_o              <= 16'h0;
         chipset_post_divider_o       <= POST_RATIO[0];
         main_pll_program_enable_o    <= 1'b0;
         chipset_pll_program_enable_o <= 1'b0;
         clock_run_o                  <= 6'h3f;
         smb_dat_q                    <= 1'b0;
      end else begin
         ref_divider_o                <= ref_eff;
         feedback_divider_o           <= fb_eff;
         vco_khz_o                    <= vco_d;
         spread_amount_o              <= {regs_q[3], regs_q[2]};
         chipset_post_divider_o       <= POST_RATIO[regs_q[4][3:0]];
         main_pll_program_enable_o    <= regs_q[6][MAIN_EN_BIT];
         chipset_pll_program_enable_o <= cs_en;
         clock_run_o                  <= run_d;
         smb_dat_q                    <= 1'b0;
      end
   end

   assign smb_dat_o = smb_dat_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   ref_div_store_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      bus.wr && bus.addr == REG_REF_DIV |=> regs_q[0][5:0] == $past(bus.wdata[5:0]))
      else $error("reference divider not stored");

   fb_high_path_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      bus.wr && bus.addr == REG_FB_HIGH && cs_en |=> ##1
      feedback_divider_o[10:3] == $past(bus.wdata, 2))
      else $error("feedback high byte not applied");

   vco_formula_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      ref_divider_o != 6'h00 |->
      vco_khz_o == 25'((VCO_REF_KHZ * 25'(feedback_divider_o)) / 25'(ref_divider_o)))
      else $error("vco frequency mismatch");

   spread_high_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      bus.wr && bus.addr == REG_SPR_HIGH |=> ##1 spread_amount_o[15:8] == $past(bus.wdata, 2))
      else $error("spread high byte not applied");

   post_ratio_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      regs_q[4][3:0] == 4'hf |=> chipset_post_divider_o == 7'd72)
      else $error("post ratio decode wrong");

   part_id_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      bus.addr == REG_PART_ID |-> bus.rdata == PART_ID_CODE)
      else $error("identification code changed");

   enable_reset_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      $rose(rst_n_q) |-> !main_pll_program_enable_o && !chipset_pll_program_enable_o)
      else $error("programming enables not cleared");

   gate_map_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      regs_q[7][5] && clock_request_n_i[4] |=> !clock_run_o[5])
      else $error("request 4 does not gate output 5");

   hold_powerup_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_q)
      !cs_en |=> ref_divider_o == RST_REF_DIV[5:0] && feedback_divider_o == 11'd249)
      else $error("divider changed while disabled");

endmodule
`default_nettype wire

// ==== sim/cpllr_smbus_host.sv ====
/*
 * smbus host model: start, stop, byte write and byte read sequences.
 * assumes an open-drain data wire with pull-up; per bit, scl high 4 clocks, low 5 clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module cpllr_smbus_host
   import cpllr_pkg::*;
(
   // clock
   input  wire logic clk_i,
   // device side of the data wire
   input  wire logic dev_dat_i,
   input  wire logic dev_oe_i,
   // smbus wire levels
   output logic      scl_o,
   output logic      sda_o
);
   logic low_q = 1'b0;
   // wired with pull-up: low when either side pulls
   assign sda_o = !(low_q || (dev_oe_i && !dev_dat_i));
   initial scl_o = 1'b1;
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask
   task automatic bit_x(input logic drv, output logic seen);
      low_q <= drv;
      half();
      scl_o <= 1'b1;
      half();
      seen = sda_o;
      scl_o <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic start();
      low_q <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      low_q <= 1'b1;
      half();
      scl_o <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic stop();
      low_q <= 1'b1;
      half();
      scl_o <= 1'b1;
      half();
      low_q <= 1'b0;
      half();
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(!b[i], s);
      bit_x(1'b0, s);
      ack = !s;
   endtask
   task automatic recv(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b0, s);
         b[i] = s;
      end
      bit_x(!last, s);
   endtask
   task automatic wr_bytes(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                           input logic two, output logic ok);
      logic [3:0] a;
      start();
      send({SMB_ADDR, 1'b0}, a[0]);
      send(cmd, a[1]);
      send(d0, a[2]);
      a[3] = 1'b1;
      if (two) send(d1, a[3]);
      stop();
      ok = &a;
   endtask
   task automatic rd_byte(input logic [7:0] cmd, input logic two, output logic [7:0] d,
                          output logic [7:0] d1, output logic ok);
      logic [2:0] a;
      start();
      send({SMB_ADDR, 1'b0}, a[0]);
      send(cmd, a[1]);
      start();
      send({SMB_ADDR, 1'b1}, a[2]);
      // master ack after the first byte when two bytes are wanted
      recv(!two, d);
      d1 = 8'h00;
      if (two) recv(1'b1, d1);
      stop();
      ok = &a;
   endtask
   task automatic probe(input logic [6:0] addr, output logic ok);
      start();
      send({addr, 1'b0}, ok);
      stop();
   endtask
endmodule
`default_nettype wire

// ==== sim/cpllr_chipset_pll_regs_tb_top.sv ====
/*
 * self-checking bench for the chipset pll control bytes.
 * assumes the host model owns the smbus wire levels.
 */
`timescale 1ns/1ps
`default_nettype none
module cpllr_chipset_pll_regs_tb_top;
   import cpllr_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [4:0]  req_n = 5'h1f;
   logic        scl, sda, dat, oe, main_en, cs_en;
   logic [5:0]  ref_div, run;
   logic [10:0] fb;
   logic [24:0] vco;
   logic [15:0] spr;
   logic [6:0]  post;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          seed = 32'h7fd9f0bd;
   logic [6:0]  ratio [16] = '{7'h02, 7'h03, 7'h05, 7'h0f, 7'h04, 7'h06, 7'h0a, 7'h12,
                               7'h08, 7'h0c, 7'h14, 7'h24, 7'h10, 7'h18, 7'h28, 7'h48};
   logic [7:0]  rst_vals [8] = '{8'h0e, 8'h1f, 8'h00, 8'h00, 8'h80, PART_ID_CODE, 8'h00, 8'h3f};
   always #12.5 ref_clk_i = ~ref_clk_i;
   cpllr_chipset_pll_regs i_cpllr_chipset_pll_regs (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .smb_clk_i(scl), .smb_dat_i(sda),
      .smb_dat_o(dat), .smb_dat_oe_o(oe), .clock_request_n_i(req_n),
      .ref_divider_o(ref_div), .feedback_divider_o(fb), .vco_khz_o(vco),
      .spread_amount_o(spr), .chipset_post_divider_o(post),
      .main_pll_program_enable_o(main_en), .chipset_pll_program_enable_o(cs_en),
      .clock_run_o(run));
   cpllr_smbus_host i_cpllr_smbus_host (
      .clk_i(ref_clk_i), .dev_dat_i(dat), .dev_oe_i(oe), .scl_o(scl), .sda_o(sda));
   // ------------------------------------------------------------
   // expectations and helpers
   // ------------------------------------------------------------
   function automatic logic [24:0] vco_of(input logic [10:0] n, input logic [5:0] m);
      return (m == 6'h00) ? 25'h0 : 25'(32'h37ee * n / m);
   endfunction
   function automatic logic [5:0] run_of(input logic [7:0] g, input logic [4:0] r);
      return ~g[5:0] | ~{r[4], r[4], r[3:0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                     input logic two);
      logic ok;
      i_cpllr_smbus_host.wr_bytes(cmd, d0, d1, two, ok);
      check(ok, 1);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] d, d1;
      logic       ok;
      i_cpllr_smbus_host.rd_byte(cmd, 1'b0, d, d1, ok);
      check(ok, 1);
      check(d, exp);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      n_mismatch++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] b10, b11, b14, g, r0, r1;
      logic       ok;
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      for (int a = 0; a < 8; a++) rd(REG_REF_DIV + 8'(a), rst_vals[a]);
      check(ref_div, 6'h0e);
      check(fb, 11'h0f9);
      check(vco, vco_of(11'h0f9, 6'h0e));
      check({main_en, cs_en}, 2'h0);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         b10 = 8'($random(seed));
         b11 = 8'($random(seed));
         b14 = 8'($random(seed)) & 8'h8f;
         if (b10[5:0] == 6'h00) b10[0] = 1'b1;
         wr(REG_PROG_EN, 8'h00, 8'h00, 1'b0);
         wr(REG_REF_DIV, b10, b11, 1'b1);
         wr(REG_POST_DIV, b14, 8'h00, 1'b0);
         if (i == 0) begin
            check(ref_div, 6'h0e);
            check(fb, 11'h0f9);
         end
         rd(REG_REF_DIV, b10);
         rd(REG_FB_HIGH, b11);
         wr(REG_PROG_EN, 8'h40, 8'h00, 1'b0);
         check({main_en, cs_en}, 2'h1);
         check(ref_div, b10[5:0]);
         check(fb, {b11, b10[7:6], b14[7]});
         check(vco, vco_of({b11, b10[7:6], b14[7]}, b10[5:0]));
         wr(REG_FB_HIGH, ~b11, 8'h00, 1'b0);
         check(fb, {~b11, b10[7:6], b14[7]});
      end
      wr(REG_PROG_EN, 8'h80, 8'h00, 1'b0);
      check({main_en, cs_en}, 2'h2);
      $display("test dividers done");
      b10 = 8'($random(seed));
      b11 = 8'($random(seed));
      wr(REG_SPR_LOW, b10, b11, 1'b1);
      check(spr, {b11, b10});
      rd(REG_SPR_HIGH, b11);
      i_cpllr_smbus_host.rd_byte(REG_SPR_LOW, 1'b1, r0, r1, ok);
      check(ok, 1);
      check({r1, r0}, {b11, b10});
      for (int c = 0; c < 16; c++) begin
         wr(REG_POST_DIV, {4'hf, 4'(c)}, 8'h00, 1'b0);
         check(post, ratio[c]);
         rd(REG_POST_DIV, {4'h8, 4'(c)});
      end
      $display("test spread and post done");
      wr(REG_PART_ID, ~PART_ID_CODE, 8'h00, 1'b0);
      rd(REG_PART_ID, PART_ID_CODE);
      i_cpllr_smbus_host.probe(SMB_ADDR ^ 7'h01, ok);
      check(ok, 0);
      rd(8'h20, 8'h00);
      $display("test id and refusals done");
      for (int i = 0; i < 6; i++) begin
         g = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         wr(REG_REQ_GATE, g, 8'h00, 1'b0);
         @(posedge ref_clk_i);
         req_n <= 5'($random(seed));
         repeat (4) @(posedge ref_clk_i);
         check(run, run_of(g, req_n));
         rd(REG_REQ_GATE, g);
      end
      $display("test gating done");
      rst_b_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check({main_en, cs_en}, 2'h0);
      check(fb, 11'h0f9);
      check(dat, 1'b0);
      rd(REG_PROG_EN, RST_PROG_EN);
      rd(REG_REQ_GATE, RST_REQ_GATE);
      $display("test reset again done");
      report_and_stop();
   end
endmodule
`default_nettype wire
